// File: rtl/ssf_port.sv
// Synchronous serial port in SPI mode with error flags and an Avalon-MM register slave.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "ssf_consts.svh"

module ssf_port (
	input  wire logic              clk_sys,          // System clock, 50 MHz.
	input  wire logic              sys_rst,          // Asynchronous reset, active high.
	input  wire logic [7:0]        avs_address,      // Byte address.
	input  wire logic              avs_read,         // Read request.
	input  wire logic              avs_write,        // Write request.
	input  wire logic [31:0]       avs_writedata,    // Write data.
	output logic [31:0]            avs_readdata,     // Read data, registered.
	output logic                   avs_waitrequest,  // Stall of the current request.
	input  wire logic              sck_i,            // Serial clock in from the pin.
	output logic                   sck_o,            // Serial clock out, master mode.
	output logic                   sck_oe,           // Serial clock drive enable.
	input  wire logic              sdi,              // Serial data in.
	output logic                   sdo_o,            // Serial data out.
	output logic                   sdo_oe,           // Serial data drive enable.
	output logic                   port_active,      // High while the pins belong to the port.
	output ssf_pkg::ssf_byte_t     rx_byte_o         // Byte held in the receive buffer.
);
	import ssf_pkg::*;

	// Control register fields.
	logic       write_collision_flag;
	logic       receive_overflow_flag;
	logic       port_enable_bit;
	logic       clock_polarity_bit;
	logic [3:0] port_mode_sel;
	logic       next_write_collision_flag, next_ovf, next_en, next_ckp;
	logic [3:0] next_mode;
	// Receive buffer and its full flag.
	ssf_byte_t  transfer_buffer, next_rxbuf;
	logic       buffer_full_flag, next_full;
	// Two-entry transmit buffer.
	ssf_byte_t  tx_mem [0:1];
	logic       tx_wptr, tx_rptr, next_wptr, next_rptr;
	logic [1:0] tx_cnt, next_txcnt;
	// Shift engine.
	ssf_state_t state, next_state;
	ssf_byte_t  shift_register, next_shreg;
	logic       sample, next_sample;
	logic [2:0] bit_cnt, next_bitcnt;
	logic [5:0] div_cnt, next_divcnt;
	logic       sck_m, next_sckm;
	logic       sck_prev;
	logic       loaded, next_loaded;
	// Bus read pipeline.
	logic       rd_pend, next_rdpend;
	logic [31:0] next_rdata;

	logic       is_master, is_slave, lead, trail, done, tx_push, tx_pop, collision;
	logic       acc_data, acc_ctrl, wr_ok, rd_done;
	logic       ovf_hit, rx_store;
	logic [5:0] half_div;
	ssf_byte_t  rx_new;

	// Mode decode and pin ownership.
	assign is_master   = (port_mode_sel[3:2] == 2'b00);
	assign is_slave    = (port_mode_sel == `SSF_MODE_SLAVE_SS) ||
	                     (port_mode_sel == `SSF_MODE_SLAVE);
	assign port_active = port_enable_bit & (is_master | is_slave);
	assign sck_o       = sck_m;
	assign sck_oe      = port_active & is_master;
	assign sdo_o       = shift_register[7];
	assign sdo_oe      = port_active;
	assign rx_byte_o   = transfer_buffer;

	// Half-period length of the generated clock per master mode.
	always_comb begin
		case (port_mode_sel[1:0])
			2'b00: half_div = `SSF_HALF_DIV0;
			2'b01: half_div = `SSF_HALF_DIV1;
			2'b10: half_div = `SSF_HALF_DIV2;
			default: half_div = `SSF_HALF_DIV3;
		endcase
	end

	// Clock edges: leading leaves the idle level, trailing returns to it.
	always_comb begin
		if (is_master) begin
			lead  = (state == SSF_SHIFT) && (div_cnt == 6'h00) && (sck_m == clock_polarity_bit);
			trail = (state == SSF_SHIFT) && (div_cnt == 6'h00) && (sck_m != clock_polarity_bit);
		end else begin
			lead  = port_active && (sck_i != clock_polarity_bit) &&
			        (sck_prev == clock_polarity_bit);
			trail = port_active && (state == SSF_SHIFT) && (sck_i == clock_polarity_bit) &&
			        (sck_prev != clock_polarity_bit);
		end
	end

	// Bus decode; a data write during a shift collides and is dropped.
	assign acc_data  = (avs_address == `SSF_OFS_DATA);
	assign acc_ctrl  = (avs_address == `SSF_OFS_CONTROL);
	assign collision = avs_write & acc_data & (state == SSF_SHIFT);
	assign avs_waitrequest = (avs_read & ~rd_pend) |
	                         (avs_write & acc_data & ~collision & (tx_cnt == 2'd2));
	assign wr_ok   = avs_write & ~avs_waitrequest;
	assign rd_done = avs_read & rd_pend;
	assign tx_push = wr_ok & acc_data & ~collision;
	assign tx_pop  = (state == SSF_IDLE) && port_active && (tx_cnt != 2'd0) &&
	                 (is_master || !loaded);
	assign done    = trail && (bit_cnt == 3'd7);
	assign rx_new  = {shift_register[6:0], sample};

	// Overflow only in slave mode; a data read at the completing edge makes room for the byte.
	assign ovf_hit  = done && is_slave && buffer_full_flag && !(rd_done && acc_data);
	assign rx_store = done && !ovf_hit;

	// Control register; software clears a flag by writing zero, a hardware set wins.
	always_comb begin
		next_write_collision_flag = write_collision_flag;
		next_ovf  = receive_overflow_flag;
		next_en   = port_enable_bit;
		next_ckp  = clock_polarity_bit;
		next_mode = port_mode_sel;
		if (wr_ok && acc_ctrl) begin
			next_write_collision_flag = write_collision_flag & avs_writedata[`SSF_BIT_WRITE_COLLISION_FLAG];
			next_ovf  = receive_overflow_flag & avs_writedata[`SSF_BIT_OVF];
			next_en   = avs_writedata[`SSF_BIT_EN];
			next_ckp  = avs_writedata[`SSF_BIT_CKP];
			next_mode = avs_writedata[3:0];
		end
		if (collision)
			next_write_collision_flag = 1'b1;
		if (ovf_hit)
			next_ovf = 1'b1;
	end

	// Registers of the control register.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			{write_collision_flag, receive_overflow_flag, port_enable_bit,
			 clock_polarity_bit, port_mode_sel} <= `SSF_CONTROL_RESET;
		end else begin
			write_collision_flag  <= next_write_collision_flag;
			receive_overflow_flag <= next_ovf;
			port_enable_bit       <= next_en;
			clock_polarity_bit    <= next_ckp;
			port_mode_sel         <= next_mode;
		end
	end

	// Receive buffer; a data read empties it, and a byte stored in the same cycle wins.
	always_comb begin
		next_rxbuf = transfer_buffer;
		next_full  = buffer_full_flag;
		if (rd_done && acc_data)
			next_full = 1'b0;
		if (rx_store) begin
			next_rxbuf = rx_new;
			next_full  = 1'b1;
		end
	end

	// Registers of the receive buffer.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			transfer_buffer  <= 8'h00;
			buffer_full_flag <= 1'b0;
		end else begin
			transfer_buffer  <= next_rxbuf;
			buffer_full_flag <= next_full;
		end
	end

	// Register reads take two cycles so that read data always comes from a flop.
	always_comb begin
		next_rdpend = rd_pend;
		next_rdata  = avs_readdata;
		if (avs_read && !rd_pend) begin
			next_rdpend = 1'b1;
			next_rdata  = 32'h0000_0000;
			if (acc_ctrl)
				next_rdata[7:0] = {write_collision_flag, receive_overflow_flag,
				                   port_enable_bit, clock_polarity_bit, port_mode_sel};
			else if (acc_data)
				next_rdata[7:0] = transfer_buffer;
			else if (avs_address == `SSF_OFS_STATUS) begin
				next_rdata[`SSF_BIT_FULL] = buffer_full_flag;
				next_rdata[`SSF_BIT_BUSY] = (state == SSF_SHIFT);
			end
		end
		if (rd_done)
			next_rdpend = 1'b0;
	end

	// Registers of the read pipeline.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rd_pend      <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			rd_pend      <= next_rdpend;
			avs_readdata <= next_rdata;
		end
	end

	// Transmit buffer entries; the write pointer picks the entry that takes the byte.
	for (genvar gi = 0; gi < 2; gi++) begin : g_tx_entry
		ssf_byte_t next_entry;

		// Next value of one entry.
		always_comb begin
			next_entry = tx_mem[gi];
			if (tx_push && (tx_wptr == 1'(gi)))
				next_entry = avs_writedata[7:0];
		end

		// Registers one entry.
		always_ff @(posedge clk_sys or posedge sys_rst) begin
			if (sys_rst)
				tx_mem[gi] <= 8'h00;
			else
				tx_mem[gi] <= next_entry;
		end
	end

	// Transmit pointers and shift engine.
	always_comb begin
		next_wptr   = tx_wptr;
		next_rptr   = tx_rptr;
		next_state  = state;
		next_shreg  = shift_register;
		next_sample = sample;
		next_bitcnt = bit_cnt;
		next_divcnt = div_cnt;
		next_sckm   = sck_m;
		next_loaded = loaded;
		if (tx_push)
			next_wptr = ~tx_wptr;
		if (tx_pop) begin
			next_shreg  = tx_mem[tx_rptr];
			next_rptr   = ~tx_rptr;
			next_loaded = 1'b1;
		end
		next_txcnt = tx_cnt + {1'b0, tx_push} - {1'b0, tx_pop};
		case (state)
			SSF_IDLE: begin
				next_sckm   = clock_polarity_bit;
				next_divcnt = half_div - 6'd1;
				next_bitcnt = 3'd0;
				if (tx_pop && is_master) begin
					next_state = SSF_SHIFT;
				end else if (lead && is_slave) begin
					next_state  = SSF_SHIFT;
					next_sample = sdi;
					next_loaded = 1'b0;
				end
			end
			SSF_SHIFT: begin
				if (is_master) begin
					if (div_cnt == 6'h00) begin
						next_sckm   = ~sck_m;
						next_divcnt = half_div - 6'd1;
					end else begin
						next_divcnt = div_cnt - 6'd1;
					end
				end
				if (lead)
					next_sample = sdi;
				if (trail) begin
					next_shreg  = rx_new;
					next_bitcnt = bit_cnt + 3'd1;
				end
				if (done)
					next_state = SSF_IDLE;
			end
			default: next_state = SSF_IDLE;
		endcase
		// Clearing the enable or leaving SPI mode stops any transfer.
		if (!port_active) begin
			next_state  = SSF_IDLE;
			next_loaded = 1'b0;
		end
	end

	// Registers of the transmit pointers and shift engine.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			tx_wptr        <= 1'b0;
			tx_rptr        <= 1'b0;
			tx_cnt         <= 2'd0;
			state          <= SSF_IDLE;
			shift_register <= 8'h00;
			sample         <= 1'b0;
			bit_cnt        <= 3'd0;
			div_cnt        <= 6'h00;
			sck_m          <= 1'b0;
			sck_prev       <= 1'b0;
			loaded         <= 1'b0;
		end else begin
			tx_wptr        <= next_wptr;
			tx_rptr        <= next_rptr;
			tx_cnt         <= next_txcnt;
			state          <= next_state;
			shift_register <= next_shreg;
			sample         <= next_sample;
			bit_cnt        <= next_bitcnt;
			div_cnt        <= next_divcnt;
			sck_m          <= next_sckm;
			sck_prev       <= sck_i;
			loaded         <= next_loaded;
		end
	end
endmodule : ssf_port

// File: rtl/ssf_consts.svh
// Register map, field positions, reset values and clock divider counts of the serial port.
// Function
// - A write to the transfer buffer while a word is still shifting sets a sticky write-collision flag that only software clears.
// - In SPI slave mode a byte that completes while the receive buffer still holds unread data sets the receive-overflow flag.
// - On overflow the newly shifted byte is thrown away and the receive buffer keeps its earlier byte.
// - Overflow can only be raised while the port runs as a slave clocked by the external master.
// - In master mode the overflow flag is never set, since each transfer starts from a software write.
// - The buffer-full bit sets when a reception completes into the receive buffer and is clear while it is empty.
// - With the port-enable bit set in SPI mode the clock, data-out and data-in pins belong to the port, else to general I/O.
`ifndef SSF_CONSTS_SVH
`define SSF_CONSTS_SVH

`define SSF_OFS_CONTROL     8'h14
`define SSF_OFS_DATA        8'h18
`define SSF_OFS_STATUS      8'h1c
`define SSF_CONTROL_RESET   8'h00
`define SSF_BIT_WRITE_COLLISION_FLAG        7
`define SSF_BIT_OVF         6
`define SSF_BIT_EN          5
`define SSF_BIT_CKP         4
`define SSF_BIT_FULL        0
`define SSF_BIT_BUSY        1
`define SSF_HALF_DIV0       6'h02
`define SSF_HALF_DIV1       6'h08
`define SSF_HALF_DIV2       6'h20
`define SSF_HALF_DIV3       6'h3f
`define SSF_MODE_SLAVE_SS   4'h4
`define SSF_MODE_SLAVE      4'h5

`endif

// File: rtl/ssf_pkg.sv
// Types shared by the serial port design.
package ssf_pkg;
	typedef enum logic [0:0] {SSF_IDLE, SSF_SHIFT} ssf_state_t;
	typedef logic [7:0] ssf_byte_t;
endpackage : ssf_pkg

// File: tb/ssf_port_asserts.sv
// Concurrent checks on the serial port's register bus, pins and receive buffer.
`timescale 1ns/1ps
`include "ssf_consts.svh"
module ssf_port_asserts (
	input logic               clk_sys,         // Clock.
	input logic               sys_rst,         // Reset.
	input logic [7:0]         avs_address,     // Address.
	input logic               avs_read,        // Read.
	input logic               avs_write,       // Write.
	input logic [31:0]        avs_writedata,   // Write data.
	input logic [31:0]        avs_readdata,    // Read data.
	input logic               avs_waitrequest, // Stall.
	input logic               sck_oe,          // Clock drive.
	input logic               sdo_oe,          // Data drive.
	input logic               port_active,     // Pin owner.
	input ssf_pkg::ssf_byte_t rx_byte_o        // Receive buffer.
);
	import ssf_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	ssf_byte_t prev_rx;
	logic      fresh;
	logic      next_fresh;
	logic      rd_data;
	logic      ctl_wr;
	// Bus events seen at an accepting edge.
	assign rd_data = avs_read && !avs_waitrequest && avs_address == `SSF_OFS_DATA;
	assign ctl_wr = avs_write && !avs_waitrequest && avs_address == `SSF_OFS_CONTROL;
	// A new receive byte stays unread until software takes it from the data register.
	always_comb begin
		next_fresh = fresh;
		if (rd_data)
			next_fresh = 1'b0;
		if (rx_byte_o != prev_rx)
			next_fresh = 1'b1;
	end
	// Registers the tracking state.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			fresh <= 1'b0;
			prev_rx <= 8'h00;
		end else begin
			fresh <= next_fresh;
			prev_rx <= rx_byte_o;
		end
	end
	sequence rd_req;
		$rose(avs_read);
	endsequence
	sequence rd_done;
		avs_read && !avs_waitrequest;
	endsequence
	rd_wait_a: assert property (rd_req |-> avs_waitrequest ##1 rd_done)
		else $error("read answer not in second cycle");
	rd_high_a: assert property (rd_done |-> avs_readdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	unmap_zero_a: assert property ((rd_done and !(avs_address inside {`SSF_OFS_CONTROL,
		`SSF_OFS_DATA, `SSF_OFS_STATUS})) |-> avs_readdata == 32'h00000000)
		else $error("unmapped read not zero");
	pin_own_a: assert property (sdo_oe == port_active)
		else $error("data drive differs from pin owner");
	sck_own_a: assert property (sck_oe |-> port_active)
		else $error("clock driven while pins released");
	ctl_off_a: assert property (ctl_wr && !avs_writedata[5] |=> !port_active && !sck_oe)
		else $error("pins kept after disable");
	ctl_slave_a: assert property (ctl_wr && avs_writedata[5:0] == 6'h25 |=> port_active && !sck_oe)
		else $error("slave enable did not take pins");
	rx_hold_a: assert property (fresh && port_active && !sck_oe && !rd_data |=> $stable(rx_byte_o))
		else $error("unread receive byte overwritten in slave mode");
endmodule : ssf_port_asserts

bind ssf_port ssf_port_asserts u_ssf_port_asserts (.*);

// File: tb/ssf_spi_master.sv
// Model of the external SPI master that clocks the port in slave mode.
`timescale 1ns/1ps
module ssf_spi_master (
	input  logic       clk_sys, // Paces the bits.
	input  logic       m_sdo,   // Data from the port.
	output logic       m_sck,   // Serial clock, idles low between frames.
	output logic       m_sdi,   // Data to the port.
	output logic [7:0] m_got    // Byte taken from the port in the last frame.
);
	// Idle levels before the first frame.
	initial begin
		m_sck = 1'b0;
		m_sdi = 1'b0;
		m_got = 8'h00;
	end
	// Sends one byte MSB first, data set up half a period before each leading edge.
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			m_sdi <= b[i];
			repeat (4) @(posedge clk_sys);
			m_sck <= 1'b1;
			m_got[i] <= m_sdo; // The port's bit has stood since its last trailing edge.
			repeat (4) @(posedge clk_sys);
			m_sck <= 1'b0;
		end
		repeat (4) @(posedge clk_sys);
		m_sdi <= ~b[0]; // A released line shows no stale bit.
	endtask : send
endmodule : ssf_spi_master

// File: tb/ssf_port_test.sv
// Testbench for the serial port: register access, slave overflow, master collision.
`timescale 1ns/1ps
module ssf_port_test;
	import ssf_pkg::*;
	localparam logic [7:0] ctl = 8'h14;
	localparam logic [7:0] dat = 8'h18;
	localparam logic [7:0] sts = 8'h1c;
	logic        clk_sys = 0;
	logic        sys_rst = 1;
	logic        avs_read = 0;
	logic        avs_write = 0;
	logic [7:0]  avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rd;
	logic        avs_waitrequest, sck_o, sck_oe, sdo_o, sdo_oe, port_active, m_sck, m_sdi;
	logic [7:0]  m_got;
	ssf_byte_t   rx_byte_o;
	wire         sck_i = sck_oe ? sck_o : m_sck;
	wire         sdi = m_sdi;
	int          n_fail = 0;
	int          n_tests = 0;
	// Clock, design and far-side master.
	always #10 clk_sys = ~clk_sys;
	ssf_port u_ssf_port (.*);
	ssf_spi_master u_ssf_spi_master (.clk_sys, .m_sdo(sdo_o), .m_sck, .m_sdi, .m_got);
	// Reports, compares and speaks the register bus.
	task automatic results();
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wait_ack();
		for (int i = 0; i < 50; i++) begin
			@(posedge clk_sys);
			if (avs_waitrequest === 1'b0)
				return;
		end
		check("bus answer", 0, 1);
		results();
	endtask : wait_ack
	task automatic bus_wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_sys);
		avs_write <= 1'b1;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		wait_ack();
		avs_write <= 1'b0;
	endtask : bus_wr
	task automatic rd_chk(string what, logic [7:0] a, logic [31:0] exp, bit cmp = 1);
		@(posedge clk_sys);
		avs_read <= 1'b1;
		avs_address <= a;
		wait_ack();
		rd = avs_readdata;
		avs_read <= 1'b0;
		if (cmp)
			check(what, exp, rd);
	endtask : rd_chk
	task automatic wait_idle();
		for (int i = 0; i < 30; i++) begin
			rd_chk("", sts, 0, 0);
			if (rd[1] === 1'b0)
				return;
		end
		check("shift end", 0, 1);
		results();
	endtask : wait_idle
	// Main sequence.
	initial begin
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd_chk("control reset", ctl, 32'h00);
		rd_chk("unmapped", 8'h20, 32'h00);
		bus_wr(ctl, 8'h25);
		@(posedge clk_sys);
		check("slave pins", 1, port_active);
		u_ssf_spi_master.send(8'ha5);
		rd_chk("full", sts, 32'h01);
		u_ssf_spi_master.send(8'h3c);
		rd_chk("overflow", ctl, 32'h65);
		check("kept byte", 8'ha5, rx_byte_o);
		rd_chk("data", dat, 32'ha5);
		rd_chk("empty", sts, 32'h00);
		bus_wr(ctl, 8'h25);
		bus_wr(dat, 8'hc3);
		u_ssf_spi_master.send(8'h5a);
		check("slave sent", 8'hc3, m_got);
		rd_chk("data two", dat, 32'h5a);
		rd_chk("no overflow", ctl, 32'h25);
		bus_wr(ctl, 8'h20);
		bus_wr(dat, 8'h81);
		rd_chk("busy", sts, 32'h02);
		bus_wr(dat, 8'h7e);
		wait_idle();
		rd_chk("collision", ctl, 32'ha0);
		bus_wr(dat, 8'h11);
		wait_idle();
		rd_chk("master no overflow", ctl, 32'ha0);
		rd_chk("master full", sts, 32'h01);
		bus_wr(ctl, 8'h00);
		@(posedge clk_sys);
		check("pins released", 0, port_active);
		results();
	end
endmodule : ssf_port_test
